// [hw/urx_pkg.sv]
// package: register map, field layout, reset values and types of the serial receiver
package urx_pkg;

  // bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register byte addresses
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_BAUD   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_DATA   = 8'h0C;

  // control register bit positions
  localparam int CTL_UART_ON  = 0;
  localparam int CTL_RX_EN    = 1;
  localparam int CTL_WORD_LEN = 2;
  localparam int CTL_PAR_EN   = 3;
  localparam int CTL_PAR_ODD  = 4;
  localparam int CTL_IRQ_EN   = 5;

  // status register bit positions
  localparam int STS_AVAIL = 0;
  localparam int STS_OVR   = 1;
  localparam int STS_FRAME_ERR_FLAG  = 2;
  localparam int STS_PARITY_ERR_FLAG  = 3;
  localparam int STS_NOISE = 4;
  localparam int STS_IDLE  = 5;
  localparam int STS_NINTH = 6;

  // widths and reset values
  localparam int BAUD_W = 16;
  localparam int WORD_W = 9;
  localparam logic [BAUD_W-1:0] BAUD_RST = 16'h0000;

  // oversampling: sixteen ticks per bit, votes at ticks 7, 8 and 9
  localparam logic [3:0] OS_S1   = 4'h7;
  localparam logic [3:0] OS_S2   = 4'h8;
  localparam logic [3:0] OS_MID  = 4'h9;
  localparam logic [3:0] OS_LAST = 4'hF;

  // data bits per frame for each word length
  localparam logic [3:0] BITS_8 = 4'h8;
  localparam logic [3:0] BITS_9 = 4'h9;

  // receive fifo depth
  localparam logic [1:0] FIFO_DEPTH = 2'h2;

  typedef struct packed {
    logic uart_on;
    logic rx_en_bit;
    logic word_len_sel;
    logic parity_en;
    logic parity_odd_sel;
    logic rx_irq_en;
  } urx_ctrl_s;

  typedef struct packed {
    logic [WORD_W-1:0] data;
    logic              frame_err_flag;
    logic              parity_err_flag;
    logic              noise;
  } urx_entry_s;

  typedef enum logic [4:0] {
    ST_HUNT  = 5'b00001,
    ST_START = 5'b00010,
    ST_DATA  = 5'b00100,
    ST_STOP  = 5'b01000,
    ST_HOLD  = 5'b10000
  } urx_state_e;

endpackage

// [hw/urx_receiver.sv]
// serial receive half with apb register access and two-word receive fifo
// Function
// [R1] accepts 8 or 9 bits; ninth bit kept
// [R2] recovery at 16x baud, shifter per bit
// [R3] bit level is majority of three samples
// [R4] stop sampled: word moves into fifo if room
// [R5] bits arrive least significant first
// [R6] fifo holds two words, third shifting in
// [R7] third word on full fifo sets overrun
// [R8] once enabled, receiver hunts for start bit
// [R9] avail while fifo holds data; irq per push
// [R10] avail cleared only by status-then-data read; module disable and reset also empty the fifo and clear it
// [R11] overrun also raises receive irq when enabled
// [R12] overrun cleared by status-then-data read sequence
// [R13] break completes as zero word with framing error
// [R14] after break wait high before next start
// [R15] idle low start to stop, high otherwise
// [R16] noise flag rides with word, no irq
// [R17] noise cleared by status-then-data read sequence
// [R18] low first stop bit sets framing error
// [R19] framing and parity errors cleared by reset
// [R20] parity error only when parity is enabled
// [R21] software reads error flags before data word
// [R22] shift register not visible to software
// [R23] software configures format and baud before enabling
// [R24] module disable flushes fifo and clears flags
// [R25] exactly one stop bit checked per frame
// [R26] each clear sequence pops exactly one word
`timescale 1ns/1ps
module urx_receiver #(
  parameter int ADDR_W = urx_pkg::ADDR_W
) (
  input  wire logic              sys_clk,
  input  wire logic              sys_rst,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  input  wire logic              rx_pin,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   rx_irq
);

  // registers and state
  urx_pkg::urx_ctrl_s                 ctrl;
  logic [urx_pkg::BAUD_W-1:0]         baud_divisor;
  logic [urx_pkg::BAUD_W-1:0]         baud_cnt;
  urx_pkg::urx_state_e                state;
  urx_pkg::urx_state_e                next_state;
  logic [3:0]                         os_cnt;
  logic [3:0]                         bit_idx;
  logic                               samp1;
  logic                               samp2;
  logic [urx_pkg::WORD_W-1:0]         rx_shift_reg;
  logic                               frame_noise;
  urx_pkg::urx_entry_s                rx_data_fifo [2];
  logic                               wr_ptr;
  logic                               rd_ptr;
  logic [1:0]                         count;
  logic                               overrun_flag;
  logic                               status_seen;
  logic                               rd_held;

  // majority of three samples
  function automatic logic maj3(input logic a, input logic b, input logic c);
    maj3 = (a & b) | (a & c) | (b & c);
  endfunction

  // apb decode
  wire apb_wait   = psel & penable & ~pready;
  wire apb_done   = psel & penable & pready;
  wire hit_ctrl   = (paddr == urx_pkg::OFS_CTRL);
  wire hit_baud   = (paddr == urx_pkg::OFS_BAUD);
  wire hit_status = (paddr == urx_pkg::OFS_STATUS);
  wire hit_data   = (paddr == urx_pkg::OFS_DATA); // shift register has no address, see [R22]
  wire hit_any    = hit_ctrl | hit_baud | hit_status | hit_data;
  wire wr_ctrl    = apb_done & pwrite & hit_ctrl;
  wire wr_baud    = apb_done & pwrite & hit_baud;
  wire rd_status  = apb_done & ~pwrite & hit_status;
  wire rd_data    = apb_done & ~pwrite & hit_data;

  // receiver timing: tick at 16x the bit rate
  wire rx_active = ctrl.uart_on & ctrl.rx_en_bit;
  wire tick      = rx_active & (baud_cnt == baud_divisor); // see [R2]
  wire mid       = tick & (os_cnt == urx_pkg::OS_MID);
  wire bit_end   = tick & (os_cnt == urx_pkg::OS_LAST); // shifter advances once per bit, see [R2]
  wire vote      = maj3(samp1, samp2, rx_pin); // see [R3]
  wire disagree  = ~((samp1 == samp2) & (samp2 == rx_pin));
  wire [3:0] last_bit = ctrl.word_len_sel ? urx_pkg::BITS_9 - 4'h1 : urx_pkg::BITS_8 - 4'h1; // see [R1]

  // frame completion and fifo moves
  wire flush      = ~ctrl.uart_on;
  wire word_done  = (state == urx_pkg::ST_STOP) & mid; // one stop bit only, see [R25]
  wire fifo_full  = (count == urx_pkg::FIFO_DEPTH);
  wire pop        = rd_data & status_seen & rd_held; // only a word that was returned, see [R10] [R26]
  wire push       = word_done & (~fifo_full | pop); // a pop in the same cycle frees the slot, see [R4]
  wire ovr_evt    = word_done & fifo_full & ~pop; // see [R7]
  wire frame_err  = ~vote; // see [R18]
  wire par_err    = ctrl.parity_en & ((^rx_shift_reg) != ctrl.parity_odd_sel); // see [R20]
  wire rx_idle    = (state == urx_pkg::ST_HUNT) | (state == urx_pkg::ST_HOLD); // see [R15]

  // head of fifo and read mux; error flags shown are those of the head word
  urx_pkg::urx_entry_s head;
  assign head = (count != 2'h0) ? rx_data_fifo[rd_ptr] : '0;
  wire [31:0] status_word = {25'h0, head.data[8], rx_idle, head.noise, head.parity_err_flag, head.frame_err_flag,
                             overrun_flag, (count != 2'h0)}; // see [R9] [R16]
  wire [31:0] ctrl_word   = {26'h0, ctrl.rx_irq_en, ctrl.parity_odd_sel, ctrl.parity_en,
                             ctrl.word_len_sel, ctrl.rx_en_bit, ctrl.uart_on};
  wire [31:0] rd_mux      = hit_ctrl   ? ctrl_word :
                            hit_baud   ? {16'h0, baud_divisor} :
                            hit_status ? status_word :
                            hit_data   ? {23'h0, head.data} : 32'h0;

  // apb answer: one wait cycle so every output comes from a flop
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
      rd_held <= 1'b0;
    end else begin
      pready  <= apb_wait;
      prdata  <= (apb_wait & ~pwrite) ? rd_mux : 32'h0;
      pslverr <= apb_wait & ~hit_any;
      rd_held <= apb_wait & (count != 2'h0); // a word landing after an empty read is not popped
    end
  end

  // control and baud registers; disabling the module drops the receiver enable
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ctrl         <= '0;
      baud_divisor <= urx_pkg::BAUD_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl.uart_on        <= pwdata[urx_pkg::CTL_UART_ON];
        ctrl.rx_en_bit      <= pwdata[urx_pkg::CTL_RX_EN] & pwdata[urx_pkg::CTL_UART_ON]; // see [R24]
        ctrl.word_len_sel   <= pwdata[urx_pkg::CTL_WORD_LEN];
        ctrl.parity_en      <= pwdata[urx_pkg::CTL_PAR_EN];
        ctrl.parity_odd_sel <= pwdata[urx_pkg::CTL_PAR_ODD];
        ctrl.rx_irq_en      <= pwdata[urx_pkg::CTL_IRQ_EN];
      end
      if (wr_baud) begin
        baud_divisor <= pwdata[urx_pkg::BAUD_W-1:0];
      end
    end
  end

  // baud divider; held at zero while the receiver is off
  always_ff @(posedge sys_clk) begin
    if (sys_rst | ~rx_active | tick) begin
      baud_cnt <= '0;
    end else begin
      baud_cnt <= baud_cnt + 16'h1;
    end
  end

  // receive sequencer
  always_comb begin
    next_state = state;
    unique case (state)
      urx_pkg::ST_HUNT: begin
        if (tick & ~rx_pin) begin
          next_state = urx_pkg::ST_START; // see [R8]
        end
      end
      urx_pkg::ST_START: begin
        if (mid & vote) begin
          next_state = urx_pkg::ST_HUNT; // glitch, not a start bit
        end else if (bit_end) begin
          next_state = urx_pkg::ST_DATA;
        end
      end
      urx_pkg::ST_DATA: begin
        if (bit_end & (bit_idx == last_bit)) begin
          next_state = urx_pkg::ST_STOP;
        end
      end
      urx_pkg::ST_STOP: begin
        if (mid) begin
          next_state = vote ? urx_pkg::ST_HUNT : urx_pkg::ST_HOLD; // see [R14]
        end
      end
      urx_pkg::ST_HOLD: begin
        if (tick & rx_pin) begin
          next_state = urx_pkg::ST_HUNT; // a held-low line is never a new start, see [R14]
        end
      end
    endcase
  end

  // state, oversample counter and sample capture
  always_ff @(posedge sys_clk) begin
    if (sys_rst | ~rx_active) begin
      state  <= urx_pkg::ST_HUNT;
      os_cnt <= 4'h0;
      samp1  <= 1'b1;
      samp2  <= 1'b1;
    end else begin
      state  <= next_state;
      os_cnt <= (next_state == urx_pkg::ST_HUNT) ? 4'h0 : (tick ? os_cnt + 4'h1 : os_cnt);
      if (tick & (os_cnt == urx_pkg::OS_S1)) begin
        samp1 <= rx_pin;
      end
      if (tick & (os_cnt == urx_pkg::OS_S2)) begin
        samp2 <= rx_pin;
      end
    end
  end

  // data shifter: lsb first, new bit enters at the top of the word
  always_ff @(posedge sys_clk) begin
    if (sys_rst | (state == urx_pkg::ST_START)) begin
      rx_shift_reg <= '0;
      bit_idx      <= 4'h0;
    end else if (state == urx_pkg::ST_DATA) begin
      if (mid) begin
        rx_shift_reg <= ctrl.word_len_sel ? {vote, rx_shift_reg[8:1]}
                                          : {1'b0, vote, rx_shift_reg[7:1]}; // see [R5] [R1]
      end
      if (bit_end) begin
        bit_idx <= bit_idx + 4'h1;
      end
    end
  end

  // noise gathered over a whole frame; a break leaves the shifter at zero
  always_ff @(posedge sys_clk) begin
    if (sys_rst | (state == urx_pkg::ST_HUNT)) begin
      frame_noise <= 1'b0;
    end else if (mid & disagree) begin
      frame_noise <= 1'b1; // see [R16]
    end
  end

  // fifo storage; error flags travel with their word
  always_ff @(posedge sys_clk) begin
    if (push) begin
      rx_data_fifo[wr_ptr] <= '{data: rx_shift_reg, frame_err_flag: frame_err, parity_err_flag: par_err,
                                noise: frame_noise | disagree}; // see [R13] [R16] [R18]
    end
  end

  // fifo pointers and fill level; reset and disable empty it
  always_ff @(posedge sys_clk) begin
    if (sys_rst | flush) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0; // error flags of stored words vanish, see [R19] [R24]
    end else begin
      if (push) begin
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr; // see [R26] [R17]
      end
      count <= count + {1'b0, push} - {1'b0, pop}; // see [R6]
    end
  end

  // overrun flag: fifo kept, new word dropped; a set beats a clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (sys_rst | flush) begin
      overrun_flag <= 1'b0;
    end else if (ovr_evt) begin
      overrun_flag <= 1'b1; // see [R7]
    end else if (pop | (rd_data & status_seen)) begin
      overrun_flag <= 1'b0; // see [R12]
    end
  end

  // status read arms the clear; the following data read consumes it
  always_ff @(posedge sys_clk) begin
    if (sys_rst | flush) begin
      status_seen <= 1'b0;
    end else if (rd_status) begin
      status_seen <= 1'b1;
    end else if (rd_data) begin
      status_seen <= 1'b0; // see [R10]
    end
  end

  // receive interrupt request, one pulse per push or overrun
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rx_irq <= 1'b0;
    end else begin
      rx_irq <= (push | ovr_evt) & ctrl.rx_irq_en; // see [R9] [R11]
    end
  end

  // checks
  push_irq_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // see [R9]
    (push & ctrl.rx_irq_en) |=> rx_irq) else $error("push without irq pulse");

  ovr_irq_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // see [R11]
    (ovr_evt & ctrl.rx_irq_en) |=> (rx_irq & overrun_flag)) else $error("overrun without irq");

  ovr_keep_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // see [R7]
    ovr_evt |=> (count == urx_pkg::FIFO_DEPTH) && (rd_ptr == $past(rd_ptr)))
    else $error("overrun disturbed fifo");

  no_pop_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // see [R10]
    (rd_data & ~status_seen & ~push & ctrl.uart_on) |=> (count == $past(count)))
    else $error("data read alone popped fifo");

  start_hunt_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // see [R8]
    (state == urx_pkg::ST_HUNT && tick && !rx_pin) |=> (state == urx_pkg::ST_START) && !rx_idle)
    else $error("start edge missed");

  break_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // see [R14]
    (state == urx_pkg::ST_HOLD && !rx_pin && rx_active) |=> (state == urx_pkg::ST_HOLD))
    else $error("low line taken as start");

  frame_err_flag_store_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // see [R18]
    (push & frame_err) |=> rx_data_fifo[$past(wr_ptr)].frame_err_flag) else $error("framing error lost");

  parity_err_flag_off_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // see [R20]
    (push & ~ctrl.parity_en) |=> !rx_data_fifo[$past(wr_ptr)].parity_err_flag) else $error("parity error while off");

  flush_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // see [R24]
    !ctrl.uart_on |-> !ctrl.rx_en_bit ##1 ((count == 2'h0) && !overrun_flag && rx_idle))
    else $error("disable did not flush");

  fifo_cap_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // see [R6]
    count <= urx_pkg::FIFO_DEPTH) else $error("fifo overfilled");

  // fifo bookkeeping, flag clearing and frame sequencing
  pop_one_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // see [R26]
    (pop & ~push & ctrl.uart_on) |=> (count == $past(count) - 2'h1))
    else $error("pop did not remove one word");

  push_one_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // see [R4]
    (push & ~pop & ctrl.uart_on) |=> (count == $past(count) + 2'h1))
    else $error("push did not add one word");

  ovr_clear_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // see [R12]
    (rd_data & status_seen & ~ovr_evt) |=> !overrun_flag)
    else $error("overrun not cleared");

  noise_store_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // see [R16]
    (push & disagree) |=> rx_data_fifo[$past(wr_ptr)].noise)
    else $error("noise lost");

  break_wait_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // see [R14]
    (word_done & ~vote) |=> (state == urx_pkg::ST_HOLD))
    else $error("break did not wait for high line");

  stop_idle_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // see [R15]
    (word_done & vote) |=> rx_idle)
    else $error("idle not raised at stop");

  stop_once_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // see [R25]
    (state == urx_pkg::ST_STOP && mid) |=> (state != urx_pkg::ST_STOP))
    else $error("second stop bit checked");

  vote_pair_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // see [R3]
    (state == urx_pkg::ST_DATA && mid && samp1 == samp2 && !ctrl.word_len_sel)
    |=> (rx_shift_reg[7] == $past(samp1)))
    else $error("majority vote wrong");

  lsb_first_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // see [R5]
    (state == urx_pkg::ST_DATA && mid && !ctrl.word_len_sel)
    |=> (rx_shift_reg[6:0] == $past(rx_shift_reg[7:1])))
    else $error("bits not shifted lsb first");

  enable_hunt_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // see [R8]
    !rx_active |=> (state == urx_pkg::ST_HUNT))
    else $error("disabled receiver left hunt");

  reset_clear_a: assert property (@(posedge sys_clk) // see [R19]
    sys_rst |=> (count == 2'h0) && !overrun_flag && (ctrl == '0))
    else $error("reset left state behind");

endmodule

// [test/urx_tx_model.sv]
// remote serial transmitter model driving the receive line
`timescale 1ns/1ps
module urx_tx_model #(
  parameter int BIT_CLKS = 16
) (
  input  wire logic sys_clk,
  output logic      rx_pin
);
  // line rests high between frames, as a real transmitter leaves it
  initial rx_pin = 1'b1;
  // clocks per bit; the bench changes it together with the divisor
  int bit_clks = BIT_CLKS;

  // one frame: start, n bits, one stop level; gl flips one clock mid-bit of frame bit gl
  task automatic send(input logic [8:0] d, input int n, input logic stp, input int gl, input int hold);
    logic lvl;
    for (int i = 0; i < n + 2; i++) begin
      lvl = (i == 0) ? 1'b0 : (i == n + 1) ? stp : d[i-1];
      for (int c = 0; c < bit_clks; c++) begin
        rx_pin <= (i == gl && c == bit_clks / 2) ? ~lvl : lvl;
        @(posedge sys_clk);
      end
    end
    // a low stop level may be stretched into a long break
    repeat (hold) @(posedge sys_clk);
    rx_pin <= 1'b1;
    repeat (2) @(posedge sys_clk);
  endtask
endmodule

// [test/urx_receiver_tb.sv]
// self-checking bench for the serial receiver: apb accesses and remote frames
`timescale 1ns/1ps
module urx_receiver_tb;
  localparam logic [31:0] AV = 32'h1 << urx_pkg::STS_AVAIL;
  localparam logic [31:0] OV = 32'h1 << urx_pkg::STS_OVR;
  localparam logic [31:0] FE = 32'h1 << urx_pkg::STS_FRAME_ERR_FLAG;
  localparam logic [31:0] PR = 32'h1 << urx_pkg::STS_PARITY_ERR_FLAG;
  localparam logic [31:0] NS = 32'h1 << urx_pkg::STS_NOISE;
  localparam logic [31:0] ID = 32'h1 << urx_pkg::STS_IDLE;
  localparam logic [31:0] N9 = 32'h1 << urx_pkg::STS_NINTH;
  localparam logic [31:0] ON = 32'h1 << urx_pkg::CTL_UART_ON;
  localparam logic [31:0] RX = 32'h1 << urx_pkg::CTL_RX_EN;
  localparam logic [31:0] W9 = 32'h1 << urx_pkg::CTL_WORD_LEN;
  localparam logic [31:0] PE = 32'h1 << urx_pkg::CTL_PAR_EN;
  localparam logic [31:0] PO = 32'h1 << urx_pkg::CTL_PAR_ODD;
  localparam logic [31:0] BASE = ON | RX | (32'h1 << urx_pkg::CTL_IRQ_EN);

  logic        sys_clk;
  logic        sys_rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic        rx_pin;
  logic        pready;
  logic        pslverr;
  logic        rx_irq;
  logic        err;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rd;
  int          err_count = 0;
  int          comparisons = 0;
  int          irq_cnt = 0;

  urx_receiver urx_receiver_i (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .rx_pin(rx_pin), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_irq(rx_irq)
  );
  urx_tx_model urx_tx_model_i (.sys_clk(sys_clk), .rx_pin(rx_pin));

  // 100 mhz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // count one-cycle receive irq pulses
  always @(posedge sys_clk) begin
    if (rx_irq === 1'b1) irq_cnt <= irq_cnt + 1;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, seen, exp);
    end
  endtask

  // one apb transfer; request held until pready is seen at an edge
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n == 50) check(32'h0, 32'h1, "pready never came");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    xfer(a, 1'b0, 32'h0);
    check(rd, exp, what);
    check({31'h0, err}, 32'h0, "slave error on mapped read");
  endtask

  // program the format, receive one frame, then status, pop and empty status
  task automatic frame_chk(input logic [31:0] ctl, input logic [8:0] d, input int n, input int gl,
                           input logic stp, input int hold, input logic [31:0] sts, input logic [31:0] dat);
    int irq0;
    xfer(urx_pkg::OFS_CTRL, 1'b1, ctl);
    irq0 = irq_cnt;
    urx_tx_model_i.send(d, n, stp, gl, hold);
    check(32'(irq_cnt - irq0), 32'h1, "irq pulses");
    rd_chk(urx_pkg::OFS_STATUS, sts, "status");
    rd_chk(urx_pkg::OFS_DATA, dat, "data");
    rd_chk(urx_pkg::OFS_STATUS, ID, "status after pop");
  endtask

  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // hang guard, far beyond the few thousand cycles the tests need
  initial begin
    repeat (40000) @(posedge sys_clk);
    err_count++;
    conclude();
  end

  initial begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    rd_chk(urx_pkg::OFS_CTRL, 32'h0, "ctrl reset");
    rd_chk(urx_pkg::OFS_BAUD, 32'h0, "baud reset");
    xfer(8'h10, 1'b0, 32'h0);
    check({31'h0, err}, 32'h1, "unmapped error");
    urx_tx_model_i.send(9'h0F0, 8, 1'b1, -1, 0);
    rd_chk(urx_pkg::OFS_STATUS, ID, "receiver off, nothing taken");
    $display("test reset done");
    // idle low mid-frame, then three frames into a two-deep fifo
    xfer(urx_pkg::OFS_BAUD, 1'b1, 32'h0);
    xfer(urx_pkg::OFS_CTRL, 1'b1, BASE);
    rd_chk(urx_pkg::OFS_CTRL, BASE, "ctrl readback");
    fork
      urx_tx_model_i.send(9'h011, 8, 1'b1, -1, 0);
      begin
        repeat (60) @(posedge sys_clk);
        rd_chk(urx_pkg::OFS_STATUS, 32'h0, "idle low in frame");
        rd_chk(urx_pkg::OFS_DATA, 32'h0, "empty data read disarms clear");
      end
    join
    urx_tx_model_i.send(9'h022, 8, 1'b1, -1, 0);
    urx_tx_model_i.send(9'h033, 8, 1'b1, -1, 0);
    check(32'(irq_cnt), 32'h3, "push and overrun irqs");
    rd_chk(urx_pkg::OFS_DATA, 32'h11, "data read alone keeps head");
    rd_chk(urx_pkg::OFS_STATUS, AV | OV | ID, "overrun");
    rd_chk(urx_pkg::OFS_DATA, 32'h11, "first word kept");
    rd_chk(urx_pkg::OFS_STATUS, AV | ID, "overrun cleared");
    rd_chk(urx_pkg::OFS_DATA, 32'h22, "second word");
    rd_chk(urx_pkg::OFS_STATUS, ID, "fifo empty");
    $display("test overrun done");
    frame_chk(BASE | W9, 9'h1C3, 9, -1, 1'b1, 0, AV | ID | N9, 32'h1C3);
    frame_chk(BASE | PE, 9'h003, 8, -1, 1'b1, 0, AV | ID, 32'h003);
    frame_chk(BASE | PE, 9'h007, 8, -1, 1'b1, 0, AV | ID | PR, 32'h007);
    frame_chk(BASE | PE | PO, 9'h007, 8, -1, 1'b1, 0, AV | ID, 32'h007);
    frame_chk(BASE | PE | PO, 9'h003, 8, -1, 1'b1, 0, AV | ID | PR, 32'h003);
    frame_chk(BASE, 9'h007, 8, -1, 1'b1, 0, AV | ID, 32'h007);
    // divisor 1 gives two clocks per tick; receiver off while the divisor changes
    xfer(urx_pkg::OFS_CTRL, 1'b1, ON);
    xfer(urx_pkg::OFS_BAUD, 1'b1, 32'h1);
    urx_tx_model_i.bit_clks = 32;
    frame_chk(BASE, 9'h0A5, 8, -1, 1'b1, 0, AV | ID, 32'h0A5);
    rd_chk(urx_pkg::OFS_BAUD, 32'h1, "baud readback");
    xfer(urx_pkg::OFS_CTRL, 1'b1, ON);
    xfer(urx_pkg::OFS_BAUD, 1'b1, 32'h0);
    urx_tx_model_i.bit_clks = 16;
    frame_chk(BASE, 9'h05A, 8, 4, 1'b1, 0, AV | ID | NS, 32'h05A);
    frame_chk(BASE, 9'h055, 8, -1, 1'b0, 0, AV | ID | FE, 32'h055);
    frame_chk(BASE, 9'h000, 8, -1, 1'b0, 200, AV | ID | FE, 32'h000);
    $display("test formats done");
    // module disable with a full fifo and pending overrun
    repeat (3) urx_tx_model_i.send(9'h066, 8, 1'b1, -1, 0);
    xfer(urx_pkg::OFS_CTRL, 1'b1, RX);
    rd_chk(urx_pkg::OFS_CTRL, 32'h0, "receiver enable cleared");
    rd_chk(urx_pkg::OFS_STATUS, ID, "flags cleared, idle set");
    // framing error left unread, then reset
    xfer(urx_pkg::OFS_CTRL, 1'b1, BASE);
    urx_tx_model_i.send(9'h055, 8, 1'b0, -1, 0);
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    xfer(urx_pkg::OFS_STATUS, 1'b0, 32'h0);
    check(rd & (AV | FE | PR), 32'h0, "errors cleared by reset");
    $display("test disable and reset done");
    conclude();
  end
endmodule
